// ===== logic/rhs_dev.sv
`timescale 1ns/100ps
`default_nettype none
module rhs_dev #(
   parameter int INIT_CYC = rhs_pkg::ms_cyc(rhs_pkg::INIT_MS),
   parameter int HEART_CYC = rhs_pkg::ms_cyc(rhs_pkg::HEART_MS) / 2,
   parameter int WDG_CYC = rhs_pkg::ms_cyc(rhs_pkg::WDG_MS),
   parameter int RPT_CYC = rhs_pkg::ms_cyc(rhs_pkg::REPORT_MS)
) (
   input wire logic clk,
   input wire logic resetn,
   rhs_link_if.dev lnk,
   input wire logic usb_enum_done,
   input wire logic det_valid,
   input wire logic [7:0] det_speed,
   input wire logic [7:0] det_mag,
   input wire logic det_toward,
   input wire logic wdg_service,
   output logic init_done,
   output logic led_enum,
   output logic led_heart,
   output logic led_rgb_r,
   output logic led_rgb_g,
   output logic led_rgb_b,
   output logic board_reset,
   output logic [1:0] reset_cause
);
   // reset pin and reset cause, on the power-on reset only
   logic rp1_q, rp2_q, core_rst_q, core_rst_d, brd_q;
   logic [7:0] low_q, low_d;
   logic [1:0] cause_q, cause_d;
   logic pin_hit, wdg_fire;
   wire core_rstn = resetn & ~core_rst_q;

   always_comb
   begin
      low_d = rp2_q ? 8'h00 : low_q;
      if (!rp2_q && low_q != 8'(rhs_pkg::RST_MIN_CYC))
         low_d = low_q + 8'h01;
      pin_hit = !rp2_q && low_q == 8'(rhs_pkg::RST_MIN_CYC);
      core_rst_d = pin_hit | wdg_fire;
      cause_d = cause_q;
      if (pin_hit)
         cause_d = rhs_pkg::CAUSE_PIN;
      else if (wdg_fire)
         cause_d = rhs_pkg::CAUSE_WDG;
   end

   always_ff @(posedge clk or negedge resetn)
      if (!resetn)
      begin
         rp1_q <= 1'b1;
         rp2_q <= 1'b1;
         low_q <= 8'h00;
         core_rst_q <= 1'b0;
         cause_q <= rhs_pkg::CAUSE_POWER;
         brd_q <= 1'b0;
      end
      else
      begin
         rp1_q <= lnk.host_rst_n;
         rp2_q <= rp1_q;
         low_q <= low_d;
         core_rst_q <= core_rst_d;
         cause_q <= cause_d;
         brd_q <= wdg_fire;
      end

   // functional state, also cleared by the pin and the watchdog
   logic rx1_q, rx2_q;
   rhs_pkg::rhs_rx_t rx_q, rx_d;
   rhs_pkg::rhs_tx_t tx_q, tx_d;
   logic [31:0] init_cnt_q, init_cnt_d, hb_cnt_q, hb_cnt_d, wdg_cnt_q, wdg_cnt_d;
   logic [31:0] rpt_cnt_q, rpt_cnt_d;
   logic init_q, init_d, hb_q, hb_d, rpt_due_q, rpt_due_d;
   logic [1:0] miss_q, miss_d;
   logic [2:0] baud_q, baud_d;
   logic int_en_q, int_en_d, dir_en_q, dir_en_d, json_q, json_d, enum_q, enum_d;
   logic [7:0] spd_thr_q, spd_thr_d, mag_thr_q, mag_thr_d, spd_q, spd_d, mval_q, mval_d;
   rhs_pkg::rhs_arg_t arg_q, arg_d;
   logic motion_q, motion_d, toward_q, toward_d, pend_q, pend_d, creq_q, creq_d;
   logic msg_q, msg_d, mcause_q, mcause_d, txd_q, txd_d, int_n_q, int_n_d;
   logic [3:0] midx_q, midx_d;
   logic [8:0] chr;
   logic [15:0] div;
   logic qual, load;
   logic [4:0] led_q, led_d;

   always_comb
   begin
      div = rhs_pkg::baud_div(baud_q);
      rx_d = rhs_pkg::rx_step(rx_q, rx2_q, div);
      init_cnt_d = init_cnt_q;
      init_d = init_q;
      if (!init_q)
      begin
         init_cnt_d = init_cnt_q + 32'h1;
         init_d = init_cnt_q == 32'(INIT_CYC - 1);
      end
      hb_cnt_d = hb_cnt_q;
      hb_d = hb_q;
      if (init_q)
      begin
         hb_cnt_d = hb_cnt_q + 32'h1;
         if (hb_cnt_q == 32'(HEART_CYC - 1))
         begin
            hb_cnt_d = 32'h0;
            hb_d = ~hb_q;
         end
      end
      wdg_fire = 1'b0;
      wdg_cnt_d = wdg_cnt_q + 32'h1;
      miss_d = miss_q;
      if (wdg_service)
      begin
         wdg_cnt_d = 32'h0;
         miss_d = 2'h0;
      end
      else if (wdg_cnt_q == 32'(WDG_CYC - 1))
      begin
         wdg_cnt_d = 32'h0;
         if (miss_q == rhs_pkg::WDG_MISS_MAX)
            wdg_fire = 1'b1;
         else
            miss_d = miss_q + 2'h1;
      end
      baud_d = baud_q;
      int_en_d = int_en_q;
      dir_en_d = dir_en_q;
      json_d = json_q;
      spd_thr_d = spd_thr_q;
      mag_thr_d = mag_thr_q;
      arg_d = arg_q;
      creq_d = creq_q;
      if (rx_q.stb)
      begin
         arg_d = rhs_pkg::ARG_NONE;
         case (arg_q)
            rhs_pkg::ARG_BAUD:
               if (rx_q.sh[7:3] == 5'h00 && rx_q.sh[2:0] <= rhs_pkg::BAUD_IDX_MAX)
                  baud_d = rx_q.sh[2:0];
            rhs_pkg::ARG_SPD: spd_thr_d = rx_q.sh;
            rhs_pkg::ARG_MAG: mag_thr_d = rx_q.sh;
            default:
               case (rx_q.sh)
                  rhs_pkg::CMD_INT_EN: int_en_d = 1'b1;
                  rhs_pkg::CMD_INT_DIS: int_en_d = 1'b0;
                  rhs_pkg::CMD_DIR_ON: dir_en_d = 1'b1;
                  rhs_pkg::CMD_DIR_OFF: dir_en_d = 1'b0;
                  rhs_pkg::CMD_JSON: json_d = 1'b1;
                  rhs_pkg::CMD_ASCII: json_d = 1'b0;
                  rhs_pkg::CMD_BAUD: arg_d = rhs_pkg::ARG_BAUD;
                  rhs_pkg::CMD_SPD_THR: arg_d = rhs_pkg::ARG_SPD;
                  rhs_pkg::CMD_MAG_THR: arg_d = rhs_pkg::ARG_MAG;
                  rhs_pkg::CMD_CAUSE: creq_d = 1'b1;
                  default: arg_d = rhs_pkg::ARG_NONE;
               endcase
         endcase
      end
      enum_d = enum_q | usb_enum_done;
      qual = det_speed >= spd_thr_q && det_mag >= mag_thr_q;
      motion_d = motion_q;
      toward_d = toward_q;
      spd_d = spd_q;
      pend_d = pend_q;
      if (det_valid && init_q)
      begin
         motion_d = qual;
         if (qual)
         begin
            toward_d = det_toward;
            spd_d = det_speed;
            pend_d = 1'b1;
         end
      end
      rpt_cnt_d = rpt_cnt_q + 32'h1;
      rpt_due_d = rpt_due_q;
      if (rpt_cnt_q == 32'(RPT_CYC - 1))
      begin
         rpt_cnt_d = 32'h0;
         rpt_due_d = 1'b1;
      end
      // a message owns the transmitter until its last character is loaded
      msg_d = msg_q;
      mcause_d = mcause_q;
      midx_d = midx_q;
      mval_d = mval_q;
      load = 1'b0;
      chr = rhs_pkg::msg_chr(midx_q, mcause_q, json_q, mval_q, cause_q);
      if (msg_q)
      begin
         if (!tx_q.busy)
         begin
            load = 1'b1;
            midx_d = midx_q + 4'h1;
            msg_d = !chr[8];
         end
      end
      else if (creq_q)
      begin
         creq_d = rx_q.stb && arg_q == rhs_pkg::ARG_NONE && rx_q.sh == rhs_pkg::CMD_CAUSE;
         msg_d = 1'b1;
         mcause_d = 1'b1;
         midx_d = 4'h0;
      end
      else if (pend_q && rpt_due_q && init_q && !enum_q)
      begin
         msg_d = 1'b1;
         mcause_d = 1'b0;
         midx_d = json_q ? 4'h0 : rhs_pkg::MSG_NUM_IDX;
         mval_d = spd_q;
         pend_d = det_valid && init_q && qual;
         rpt_due_d = 1'b0;
      end
      tx_d = rhs_pkg::tx_step(tx_q, load, chr[7:0], div);
      txd_d = tx_d.busy ? tx_d.sh[0] : 1'b1;
      int_n_d = !(int_en_d && motion_d);
      led_d[0] = !enum_d;
      led_d[1] = dir_en_d && motion_d && toward_d;
      led_d[2] = !dir_en_d && motion_d;
      led_d[3] = dir_en_d && motion_d && !toward_d;
      led_d[4] = hb_d;
   end

   always_ff @(posedge clk or negedge core_rstn)
      if (!core_rstn)
      begin
         rx1_q <= 1'b1;
         rx2_q <= 1'b1;
         rx_q <= '0;
         tx_q <= '0;
         init_cnt_q <= 32'h0;
         init_q <= 1'b0;
         hb_cnt_q <= 32'h0;
         hb_q <= 1'b0;
         wdg_cnt_q <= 32'h0;
         miss_q <= 2'h0;
         rpt_cnt_q <= 32'h0;
         rpt_due_q <= 1'b0;
         baud_q <= rhs_pkg::BAUD_IDX_DEF;
         int_en_q <= 1'b0;
         dir_en_q <= 1'b1;
         json_q <= 1'b0;
         enum_q <= 1'b0;
         spd_thr_q <= 8'h00;
         mag_thr_q <= 8'h00;
         arg_q <= rhs_pkg::ARG_NONE;
         motion_q <= 1'b0;
         toward_q <= 1'b0;
         spd_q <= 8'h00;
         mval_q <= 8'h00;
         pend_q <= 1'b0;
         creq_q <= 1'b0;
         msg_q <= 1'b0;
         mcause_q <= 1'b0;
         midx_q <= 4'h0;
         txd_q <= 1'b1;
         int_n_q <= 1'b1;
         led_q <= 5'h01;
      end
      else
      begin
         rx1_q <= lnk.host_txd;
         rx2_q <= rx1_q;
         rx_q <= rx_d;
         tx_q <= tx_d;
         init_cnt_q <= init_cnt_d;
         init_q <= init_d;
         hb_cnt_q <= hb_cnt_d;
         hb_q <= hb_d;
         wdg_cnt_q <= wdg_cnt_d;
         miss_q <= miss_d;
         rpt_cnt_q <= rpt_cnt_d;
         rpt_due_q <= rpt_due_d;
         baud_q <= baud_d;
         int_en_q <= int_en_d;
         dir_en_q <= dir_en_d;
         json_q <= json_d;
         enum_q <= enum_d;
         spd_thr_q <= spd_thr_d;
         mag_thr_q <= mag_thr_d;
         arg_q <= arg_d;
         motion_q <= motion_d;
         toward_q <= toward_d;
         spd_q <= spd_d;
         mval_q <= mval_d;
         pend_q <= pend_d;
         creq_q <= creq_d;
         msg_q <= msg_d;
         mcause_q <= mcause_d;
         midx_q <= midx_d;
         txd_q <= txd_d;
         int_n_q <= int_n_d;
         led_q <= led_d;
      end

   assign lnk.dev_txd = txd_q;
   assign lnk.motion_int_n = int_n_q;
   assign init_done = init_q;
   assign led_enum = led_q[0];
   assign led_rgb_r = led_q[1];
   assign led_rgb_g = led_q[2];
   assign led_rgb_b = led_q[3];
   assign led_heart = led_q[4];
   assign board_reset = brd_q;
   assign reset_cause = cause_q;
endmodule
`default_nettype wire

// ===== logic/rhs_host.sv
`timescale 1ns/100ps
`default_nettype none
module rhs_host (
   input wire logic clk,
   input wire logic resetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic irq,
   rhs_link_if.host lnk
);
   logic rx1_q, rx2_q, mi1_q, mi2_q, mi3_q;
   rhs_pkg::rhs_rx_t rx_q, rx_d;
   rhs_pkg::rhs_tx_t tx_q, tx_d;
   logic [2:0] baud_q, baud_d;
   logic [7:0] rst_cnt_q, rst_cnt_d, rxb_q, rxb_d, wa_q;
   logic rxv_q, rxv_d, wr_q, txd_q, txd_d, rstn_q, rstn_d, irq_q, irq_d;
   logic [rhs_pkg::IRQ_W-1:0] ist_q, ist_d, msk_q, msk_d, iset;
   logic [31:0] hrd_q, hrd_d;
   logic [15:0] div;
   logic take, tx_load;

   always_comb
   begin
      div = rhs_pkg::baud_div(baud_q);
      rx_d = rhs_pkg::rx_step(rx_q, rx2_q, div);
      take = hsel && hready && htrans[1];
      tx_load = wr_q && wa_q == rhs_pkg::A_TX;
      tx_d = rhs_pkg::tx_step(tx_q, tx_load, hwdata[7:0], div);
      txd_d = tx_d.busy ? tx_d.sh[0] : 1'b1;
      baud_d = baud_q;
      msk_d = msk_q;
      rst_cnt_d = rst_cnt_q == 8'h00 ? 8'h00 : rst_cnt_q - 8'h01;
      ist_d = ist_q;
      if (wr_q)
         case (wa_q)
            rhs_pkg::A_CTRL:
            begin
               if (hwdata[3:1] <= rhs_pkg::BAUD_IDX_MAX)
                  baud_d = hwdata[3:1];
               if (hwdata[0])
                  rst_cnt_d = 8'(rhs_pkg::RST_HOLD_CYC);
            end
            rhs_pkg::A_IRQ: ist_d = ist_q & ~hwdata[rhs_pkg::IRQ_W-1:0];
            rhs_pkg::A_MASK: msk_d = hwdata[rhs_pkg::IRQ_W-1:0];
            default: msk_d = msk_q;
         endcase
      // a new event outranks a same-cycle write-one-to-clear
      iset = (rx_d.stb ? rhs_pkg::IRQ_RX : '0) | (mi3_q && !mi2_q ? rhs_pkg::IRQ_MOTION : '0);
      ist_d = ist_d | iset;
      irq_d = |(ist_d & msk_d);
      rstn_d = rst_cnt_d == 8'h00;
      rxb_d = rx_d.stb ? rx_d.sh : rxb_q;
      rxv_d = rxv_q;
      hrd_d = hrd_q;
      if (take && !hwrite)
      begin
         if (haddr[7:0] == rhs_pkg::A_RX)
            rxv_d = 1'b0;
         case (haddr[7:0])
            rhs_pkg::A_CTRL: hrd_d = {28'h0, baud_q, !rstn_q};
            rhs_pkg::A_STAT: hrd_d = {28'h0, !rstn_q, !mi2_q, rxv_q, tx_q.busy};
            rhs_pkg::A_RX: hrd_d = {24'h0, rxb_q};
            rhs_pkg::A_IRQ: hrd_d = {30'h0, ist_q};
            rhs_pkg::A_MASK: hrd_d = {30'h0, msk_q};
            default: hrd_d = 32'h0;
         endcase
      end
      if (rx_d.stb)
         rxv_d = 1'b1;
   end

   always_ff @(posedge clk or negedge resetn)
      if (!resetn)
      begin
         rx1_q <= 1'b1;
         rx2_q <= 1'b1;
         mi1_q <= 1'b1;
         mi2_q <= 1'b1;
         mi3_q <= 1'b1;
         rx_q <= '0;
         tx_q <= '0;
         baud_q <= rhs_pkg::BAUD_IDX_DEF;
         rst_cnt_q <= 8'h00;
         rxb_q <= 8'h00;
         rxv_q <= 1'b0;
         wr_q <= 1'b0;
         wa_q <= 8'h00;
         txd_q <= 1'b1;
         rstn_q <= 1'b1;
         ist_q <= '0;
         msk_q <= '0;
         irq_q <= 1'b0;
         hrd_q <= 32'h0;
      end
      else
      begin
         rx1_q <= lnk.dev_txd;
         rx2_q <= rx1_q;
         mi1_q <= lnk.motion_int_n;
         mi2_q <= mi1_q;
         mi3_q <= mi2_q;
         rx_q <= rx_d;
         tx_q <= tx_d;
         baud_q <= baud_d;
         rst_cnt_q <= rst_cnt_d;
         rxb_q <= rxb_d;
         rxv_q <= rxv_d;
         wr_q <= take && hwrite;
         wa_q <= haddr[7:0];
         txd_q <= txd_d;
         rstn_q <= rstn_d;
         ist_q <= ist_d;
         msk_q <= msk_d;
         irq_q <= irq_d;
         hrd_q <= hrd_d;
      end

   assign lnk.host_txd = txd_q;
   assign lnk.host_rst_n = rstn_q;
   assign hrdata = hrd_q;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign irq = irq_q;
endmodule
`default_nettype wire

// ===== logic/rhs_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface rhs_link_if;
   logic dev_txd;
   logic host_txd;
   logic motion_int_n;
   logic host_rst_n;
   modport dev (output dev_txd, output motion_int_n, input host_txd, input host_rst_n);
   modport host (input dev_txd, input motion_int_n, output host_txd, output host_rst_n);
endinterface
`default_nettype wire

// ===== logic/rhs_pkg.sv
`default_nettype none
package rhs_pkg;
   localparam int CLK_HZ = 200_000_000;
   localparam int RST_MIN_NS = 200;
   localparam int RST_MIN_CYC = (RST_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   // host stretches its reset pulse past the receiver's synchroniser
   localparam int RST_SYNC_MARGIN = 2;
   localparam int RST_HOLD_CYC = RST_MIN_CYC + RST_SYNC_MARGIN;
   localparam int INIT_MS = 300;
   localparam int HEART_MS = 1000;
   localparam int WDG_MS = 1000;
   localparam int REPORT_MS = 170;
   localparam logic [1:0] WDG_MISS_MAX = 2'd2;
   localparam logic [2:0] BAUD_IDX_DEF = 3'd3;
   localparam logic [2:0] BAUD_IDX_MAX = 3'd4;
   localparam logic [3:0] TX_LAST_BIT = 4'd9;
   localparam logic [3:0] MSG_NUM_IDX = 4'd5;
   localparam logic [1:0] CAUSE_POWER = 2'd0;
   localparam logic [1:0] CAUSE_PIN = 2'd1;
   localparam logic [1:0] CAUSE_WDG = 2'd2;
   localparam logic [7:0] CMD_INT_EN = 8'h67;
   localparam logic [7:0] CMD_INT_DIS = 8'h47;
   localparam logic [7:0] CMD_DIR_ON = 8'h44;
   localparam logic [7:0] CMD_DIR_OFF = 8'h64;
   localparam logic [7:0] CMD_JSON = 8'h6a;
   localparam logic [7:0] CMD_ASCII = 8'h4a;
   localparam logic [7:0] CMD_BAUD = 8'h62;
   localparam logic [7:0] CMD_SPD_THR = 8'h73;
   localparam logic [7:0] CMD_MAG_THR = 8'h6d;
   localparam logic [7:0] CMD_CAUSE = 8'h72;
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_STAT = 8'h04;
   localparam logic [7:0] A_TX = 8'h08;
   localparam logic [7:0] A_RX = 8'h0c;
   localparam logic [7:0] A_IRQ = 8'h10;
   localparam logic [7:0] A_MASK = 8'h14;
   localparam int IRQ_W = 2;
   localparam logic [IRQ_W-1:0] IRQ_RX = 2'b01;
   localparam logic [IRQ_W-1:0] IRQ_MOTION = 2'b10;
   typedef enum logic [1:0] {ARG_NONE = 2'b00, ARG_BAUD = 2'b01, ARG_SPD = 2'b10,
      ARG_MAG = 2'b11} rhs_arg_t;
   typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10,
      RX_STOP = 2'b11} rhs_rx_st_t;
   typedef struct packed {
      rhs_rx_st_t st;
      logic [15:0] cnt;
      logic [2:0] idx;
      logic [7:0] sh;
      logic stb;
   } rhs_rx_t;
   typedef struct packed {
      logic busy;
      logic [15:0] cnt;
      logic [3:0] idx;
      logic [9:0] sh;
   } rhs_tx_t;

   function automatic int ms_cyc(input int ms);
      return ms * (CLK_HZ / 1000);
   endfunction

   function automatic logic [15:0] baud_div(input logic [2:0] sel);
      int rate;
      case (sel)
         3'd0: rate = 9600;
         3'd1: rate = 19200;
         3'd2: rate = 38400;
         3'd3: rate = 57600;
         default: rate = 115200;
      endcase
      return 16'(CLK_HZ / rate);
   endfunction

   // 8n1 receiver, samples mid-bit; a bad stop bit drops the byte
   function automatic rhs_rx_t rx_step(input rhs_rx_t q, input logic line,
      input logic [15:0] div);
      rhs_rx_t n;
      n = q;
      n.stb = 1'b0;
      if (q.st != RX_IDLE && q.cnt != 16'h0000)
         n.cnt = q.cnt - 16'h0001;
      else
         case (q.st)
            RX_IDLE:
               if (!line)
               begin
                  n.st = RX_START;
                  n.cnt = div >> 1;
               end
            RX_START:
            begin
               n.st = line ? RX_IDLE : RX_DATA;
               n.cnt = div - 16'h0001;
               n.idx = 3'h0;
            end
            RX_DATA:
            begin
               n.sh = {line, q.sh[7:1]};
               n.cnt = div - 16'h0001;
               n.idx = q.idx + 3'h1;
               if (q.idx == 3'h7)
                  n.st = RX_STOP;
            end
            default:
            begin
               n.st = RX_IDLE;
               n.stb = line;
            end
         endcase
      return n;
   endfunction

   // start bit low, lsb first, one stop bit, idle high
   function automatic rhs_tx_t tx_step(input rhs_tx_t q, input logic load,
      input logic [7:0] data, input logic [15:0] div);
      rhs_tx_t n;
      n = q;
      if (!q.busy)
      begin
         if (load)
         begin
            n.busy = 1'b1;
            n.sh = {1'b1, data, 1'b0};
            n.cnt = div - 16'h0001;
            n.idx = 4'h0;
         end
      end
      else if (q.cnt != 16'h0000)
         n.cnt = q.cnt - 16'h0001;
      else
      begin
         n.cnt = div - 16'h0001;
         n.sh = {1'b1, q.sh[9:1]};
         n.idx = q.idx + 4'h1;
         if (q.idx == TX_LAST_BIT)
            n.busy = 1'b0;
      end
      return n;
   endfunction

   // message table {last, char}: speed {"s":ddd}\n or ddd\n, cause {"r":c}\n
   function automatic logic [8:0] msg_chr(input logic [3:0] i, input logic cause,
      input logic js, input logic [7:0] v, input logic [1:0] c);
      logic [7:0] d2;
      logic [7:0] d1;
      logic [7:0] d0;
      d2 = 8'h30 + v / 8'h64;
      d1 = 8'h30 + (v / 8'h0a) % 8'h0a;
      d0 = 8'h30 + v % 8'h0a;
      case (i)
         4'h0: msg_chr = {1'b0, 8'h7b};
         4'h1: msg_chr = {1'b0, 8'h22};
         4'h2: msg_chr = {1'b0, cause ? 8'h72 : 8'h73};
         4'h3: msg_chr = {1'b0, 8'h22};
         4'h4: msg_chr = {1'b0, 8'h3a};
         4'h5: msg_chr = {1'b0, cause ? 8'h30 + {6'h00, c} : d2};
         4'h6: msg_chr = {1'b0, cause ? 8'h7d : d1};
         4'h7: msg_chr = cause ? {1'b1, 8'h0a} : {1'b0, d0};
         4'h8: msg_chr = js ? {1'b0, 8'h7d} : {1'b1, 8'h0a};
         default: msg_chr = {1'b1, 8'h0a};
      endcase
   endfunction
endpackage
`default_nettype wire

// ===== tb/radar_module_host_signalling_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module radar_module_host_signalling_tb_top;
   logic clk, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, irq;
   logic usb_enum_done = 1'b0, det_valid = 1'b0, det_toward = 1'b0;
   logic wdg_service = 1'b0, wdg_en = 1'b0, init_done, led_enum, led_heart;
   logic led_rgb_r, led_rgb_g, led_rgb_b, board_reset, hresp;
   logic [7:0] det_speed = 8'h7b, det_mag = 8'h80;
   logic [1:0] reset_cause;
   logic [1:0] htrans = 2'b00;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   int svc_cnt = 0, cyc = 0, err_count = 0, compares = 0;
   rhs_link_if lnk ();
   rhs_dev #(.INIT_CYC(50), .HEART_CYC(20), .WDG_CYC(100), .RPT_CYC(30)) rhs_dev_i (.clk,
      .resetn, .lnk(lnk.dev), .usb_enum_done, .det_valid, .det_speed, .det_mag,
      .det_toward, .wdg_service, .init_done, .led_enum, .led_heart, .led_rgb_r, .led_rgb_g,
      .led_rgb_b, .board_reset, .reset_cause);
   rhs_host rhs_host_i (.clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .irq, .lnk(lnk.host));
   rhs_chk rhs_chk_i (.clk, .resetn, .dev_txd(lnk.dev_txd), .host_txd(lnk.host_txd),
      .motion_int_n(lnk.motion_int_n), .host_rst_n(lnk.host_rst_n));
   initial
   begin
      clk = 1'b0;
      forever
         #2.5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      svc_cnt <= (svc_cnt == 49) ? 0 : svc_cnt + 1;
      wdg_service <= wdg_en && svc_cnt == 0;
      cyc <= cyc + 1;
      if (cyc == 100000)
      begin
         err_count++;
         finish_test();
      end
   end
   task automatic finish_test();
      $display("compares %0d errors %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         err_count++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic chk1(input string nm, input logic e, input logic g);
      chk(nm, {31'h0, e}, {31'h0, g});
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h000000, a};
      hwrite <= wr;
      @(posedge clk);
      while (!hreadyout)
         @(posedge clk);
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge clk);
      while (!hreadyout)
         @(posedge clk);
      rd = hrdata;
   endtask
   // serial waits are long, so status is polled rather than timed
   task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v,
      input int lim);
      int n;
      bus(1'b0, a, 32'h0);
      for (n = 0; n < lim && (rd & m) !== v; n++)
         bus(1'b0, a, 32'h0);
      chk("poll", v, rd & m);
   endtask
   task automatic det(input logic tow);
      det_toward <= tow;
      det_valid <= 1'b1;
      @(posedge clk);
      det_valid <= 1'b0;
      repeat (4)
         @(posedge clk);
   endtask
   task automatic t_idle();
      chk1("dev_txd", 1'b1, lnk.dev_txd);
      chk1("int", 1'b1, lnk.motion_int_n);
      chk1("led_enum", 1'b1, led_enum);
      chk1("hresp", 1'b0, hresp);
      bus(1'b1, 8'h18, 32'hffffffff);
      bus(1'b0, 8'h18, 32'h0);
      chk("unmapped", 32'h0, rd);
      bus(1'b0, rhs_pkg::A_MASK, 32'h0);
      chk("mask", 32'h0, rd);
   endtask
   task automatic t_wdg();
      int n;
      wdg_en <= 1'b1;
      @(posedge clk);
      while (!wdg_service)
         @(posedge clk);
      wdg_en <= 1'b0;
      for (n = 0; n < 400 && board_reset !== 1'b1; n++)
         @(posedge clk);
      chk1("wdg fire", 1'b1, n >= 295 && n <= 305);
      wdg_en <= 1'b1;
      for (n = 0; n < 100 && init_done !== 1'b1; n++)
         @(posedge clk);
      chk1("init", 1'b1, n >= 48 && n <= 54);
      chk("cause", 32'(rhs_pkg::CAUSE_WDG), 32'(reset_cause));
   endtask
   task automatic t_heart();
      logic h;
      h = led_heart;
      for (int i = 0; i < 60 && led_heart === h; i++)
         @(posedge clk);
      h = led_heart;
      repeat (19)
         @(posedge clk);
      chk1("heart hold", h, led_heart);
      @(posedge clk);
      chk1("heart flip", !h, led_heart);
   endtask
   task automatic t_report();
      bus(1'b1, rhs_pkg::A_MASK, {30'h0, rhs_pkg::IRQ_RX});
      // command goes out while the report comes back, to save serial time
      bus(1'b1, rhs_pkg::A_TX, {24'h0, rhs_pkg::CMD_INT_EN});
      det(1'b0);
      chk1("blue", 1'b1, led_rgb_b);
      det(1'b1);
      chk1("red", 1'b1, led_rgb_r);
      chk1("green off", 1'b0, led_rgb_g);
      chk1("int off", 1'b1, lnk.motion_int_n);
      poll(rhs_pkg::A_STAT, 32'h2, 32'h2, 40000);
      chk1("irq", 1'b1, irq);
      bus(1'b0, rhs_pkg::A_RX, 32'h0);
      chk("first char", 32'h31, rd);
      bus(1'b1, rhs_pkg::A_IRQ, 32'h1);
      bus(1'b0, rhs_pkg::A_IRQ, 32'h0);
      chk("irq clr", 32'h0, rd & 32'h1);
      chk1("irq low", 1'b0, irq);
   endtask
   task automatic t_int();
      poll(rhs_pkg::A_STAT, 32'h1, 32'h0, 40000);
      bus(1'b1, rhs_pkg::A_TX, {24'h0, rhs_pkg::CMD_DIR_OFF});
      poll(rhs_pkg::A_STAT, 32'h1, 32'h1, 10);
      poll(rhs_pkg::A_STAT, 32'h1, 32'h0, 40000);
      det(1'b1);
      chk1("int on", 1'b0, lnk.motion_int_n);
      chk1("green", 1'b1, led_rgb_g);
      chk1("red off", 1'b0, led_rgb_r);
      bus(1'b0, rhs_pkg::A_IRQ, 32'h0);
      chk("motion irq", 32'h2, rd & 32'h2);
   endtask
   task automatic t_pinrst();
      bus(1'b1, rhs_pkg::A_CTRL, 32'h7);
      poll(rhs_pkg::A_STAT, 32'h8, 32'h8, 10);
      poll(rhs_pkg::A_STAT, 32'h8, 32'h0, 200);
      repeat (4)
         @(posedge clk);
      chk("pin cause", 32'h1, 32'(reset_cause));
      chk1("int idle", 1'b1, lnk.motion_int_n);
   endtask
   initial
   begin
      repeat (6)
         @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      t_idle();
      t_wdg();
      t_heart();
      t_report();
      t_int();
      t_pinrst();
      chk1("enum on", 1'b1, led_enum);
      usb_enum_done <= 1'b1;
      repeat (4)
         @(posedge clk);
      chk1("enum off", 1'b0, led_enum);
      for (int i = 0; i < 100 && init_done !== 1'b1; i++)
         @(posedge clk);
      chk1("reinit", 1'b1, init_done);
      det_speed <= 8'h05;
      det(1'b1);
      // a report would be inside its start bit by now
      repeat (60)
         @(posedge clk);
      chk1("enum quiet", 1'b1, lnk.dev_txd);
      finish_test();
   end
endmodule
`default_nettype wire

// ===== tb/rhs_chk.sv
`timescale 1ns/100ps
`default_nettype none
module rhs_chk (
   input wire logic clk,
   input wire logic resetn,
   input wire logic dev_txd,
   input wire logic host_txd,
   input wire logic motion_int_n,
   input wire logic host_rst_n
);
   logic [7:0] lo_q;
   logic [7:0] lo_d;
   // saturates so a long hold never wraps to a short count
   always_comb
      lo_d = host_rst_n ? 8'h00 : lo_q + {7'h00, lo_q != 8'hff};
   always_ff @(posedge clk or negedge resetn)
      if (!resetn)
         lo_q <= 8'h00;
      else
         lo_q <= lo_d;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence rst_lo8;
      !host_rst_n [*8];
   endsequence
   sequence rst_done;
      $rose(host_rst_n) && lo_q >= 8'h28;
   endsequence
   chk_rst_min_low: assert property ($rose(host_rst_n) |-> lo_q >= 8'h28)
      else $error("reset pulse short");
   chk_rst_low_run: assert property ($fell(host_rst_n) |-> rst_lo8)
      else $error("reset glitch");
   chk_rst_bounded: assert property ($fell(host_rst_n) |-> ##[40:50] host_rst_n)
      else $error("reset not released");
   chk_int_off_rst: assert property (rst_done |-> ##4 motion_int_n [*8])
      else $error("interrupt live after reset");
   chk_tx_quiet_rst: assert property (rst_done |-> ##4 dev_txd [*8])
      else $error("serial live after reset");
   // a core reset may cut a bit short, so the pin reset masks it
   chk_dev_bit_hold: assert property (
      disable iff (!resetn || !host_rst_n) $changed(dev_txd) |=> $stable(dev_txd) [*7])
      else $error("device bit short");
   chk_host_bit_hold: assert property ($changed(host_txd) |=> $stable(host_txd) [*7])
      else $error("host bit short");
   chk_int_low_hold: assert property ($fell(motion_int_n) |=> !motion_int_n [*2])
      else $error("interrupt glitch");
endmodule
`default_nettype wire
